// ---- dv/arsc_assertions.sv ----
`timescale 1ns/10ps
module arsc_chk #(
  parameter int SETPT_W = 8,
  parameter int PGW_TOGGLE_CYC = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_oe,
  input wire logic alert_oe,
  input wire logic state_change,
  input wire logic clear_faults,
  input wire logic on_off_req_n,
  input wire logic interlock_ok,
  input wire logic rs485_mode,
  input wire logic [SETPT_W-1:0] sw_setpoint,
  input wire logic sw_setpoint_wr,
  input wire logic out_in_regulation,
  input wire logic regulation_warn,
  input wire logic overload,
  input wire logic fan_fail,
  input wire logic over_temp_shutdown,
  input wire logic over_volt_shutdown,
  input wire logic internal_fault,
  input wire logic main_out_en,
  input wire logic [SETPT_W-1:0] setpoint,
  input wire logic presence_n,
  input wire logic output_good_warn_n,
  input wire logic fault_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_pres; presence_n == 1'b0; endproperty
  a_pres: assert property (p_pres) else $error("presence high");
  property p_en; !$past(rst) |-> main_out_en == $past(interlock_ok & (rs485_mode | ~on_off_req_n)); endproperty
  a_en: assert property (p_en) else $error("output enable wrong");
  property p_flt;
    !$past(rst) |-> fault_n == !$past(fan_fail | over_temp_shutdown | over_volt_shutdown | internal_fault);
  endproperty
  a_flt: assert property (p_flt) else $error("fault output wrong");
  property p_pg;
    !$past(rst) && !$past(overload) |-> output_good_warn_n == $past(main_out_en & out_in_regulation & ~regulation_warn);
  endproperty
  a_pg: assert property (p_pg) else $error("good warning wrong");
  property p_set; state_change |=> alert_oe; endproperty
  a_set: assert property (p_set) else $error("alert not raised");
  property p_clr; clear_faults && !state_change |=> !alert_oe; endproperty
  a_clr: assert property (p_clr) else $error("alert not cleared");
  // Release only by clear or in a low clock phase of the answer
  property p_fall; $fell(alert_oe) |-> $past(clear_faults) || !scl_i; endproperty
  a_fall: assert property (p_fall) else $error("alert dropped early");
  property p_sda; $changed(sda_oe) |-> !scl_i; endproperty
  a_sda: assert property (p_sda) else $error("data moved in high clock");
  property p_sw; !$past(rst) && $past(sw_setpoint_wr) |-> setpoint == $past(sw_setpoint); endproperty
  a_sw: assert property (p_sw) else $error("setpoint not taken");
  // Edges since the last overload toggle; zero until the first one
  logic [15:0] blk_cnt_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blk_cnt_ff <= 16'h0000;
    end else if (!overload) begin
      blk_cnt_ff <= 16'h0000;
    end else if ($past(overload) && $changed(output_good_warn_n)) begin
      blk_cnt_ff <= 16'h0001;
    end else if (blk_cnt_ff != 16'h0000) begin
      blk_cnt_ff <= blk_cnt_ff + 16'h0001;
    end
  end
  property p_blk;
    overload && $past(overload) && $changed(output_good_warn_n) && blk_cnt_ff != 16'h0000 |->
      blk_cnt_ff == 16'(PGW_TOGGLE_CYC);
  endproperty
  a_blk: assert property (p_blk) else $error("overload blink period wrong");
  property p_blk_max; overload && $past(overload) |-> blk_cnt_ff <= 16'(PGW_TOGGLE_CYC); endproperty
  a_blk_max: assert property (p_blk_max) else $error("overload blink stalled");
endmodule // arsc_chk
bind arsc_top arsc_chk #(.SETPT_W(SETPT_W), .PGW_TOGGLE_CYC(PGW_TOGGLE_CYC)) chk_u (.*);

// ---- dv/arsc_host_model.sv ----
`timescale 1ns/10ps
module arsc_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull,
  output logic in_data
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    in_data = 1'b0;
  end
  task automatic q();
    repeat (8) @(negedge clk);
  endtask
  // Host makes every clock edge
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    scl = 1'b0;
    q();
  endtask
  task automatic byte_io(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
  endtask
  // Start, read of 8'h19, ack, address, ack, check byte, nack, stop
  task automatic ara_read(output logic [7:0] adr, output logic [7:0] pec, output logic ack);
    logic [7:0] junk;
    logic a2;
    sda_pull = 1'b1;
    q();
    scl = 1'b0;
    q();
    byte_io(8'h19, junk);
    bit_io(1'b1, ack);
    in_data = 1'b1;
    byte_io(8'hFF, adr);
    in_data = 1'b0;
    bit_io(1'b0, a2);
    byte_io(8'hFF, pec);
    bit_io(1'b1, a2);
    sda_pull = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_pull = 1'b0;
    q();
  endtask
endmodule // arsc_host_model

// ---- dv/test_alert_response_status_ctrl.sv ----
`timescale 1ns/10ps
module test_alert_response_status_ctrl;
  logic clk = 1'b0, rst = 1'b1, scl_i, pull, in_data, rival = 1'b0, sda_i, ack;
  logic sda_o, sda_oe, alert_o, alert_oe, main_out_en, presence_n, output_good_warn_n, fault_n, prev;
  logic [6:0] own_address = 7'h2A;
  logic state_change = 1'b0, clear_faults = 1'b0, on_off_req_n = 1'b1, interlock_ok = 1'b0, rs485_mode = 1'b0;
  logic [7:0] hw_setpoint = 8'h5A, sw_setpoint = 8'hC3, setpoint, adr, pec;
  logic sw_setpoint_wr = 1'b0, out_in_regulation = 1'b1, regulation_warn = 1'b0, overload = 1'b0;
  logic fan_fail = 1'b0, over_temp_shutdown = 1'b0, over_volt_shutdown = 1'b0, internal_fault = 1'b0;
  int err_count = 0, n_compared = 0, n;
  // Rival answerer with address zero pulls the whole returned byte
  assign sda_i = ~(pull | (sda_oe & ~sda_o) | (rival & in_data));
  always #10 clk = ~clk;
  arsc_top #(.PGW_TOGGLE_CYC(8)) dut_u (.*);
  arsc_host_model host_u (.clk(clk), .sda(sda_i), .scl(scl_i), .sda_pull(pull), .in_data(in_data));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    c = c ^ d;
    for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    tick(16);
    rst = 1'b0;
    tick(2);
    chk(alert_oe, 8'h01);
    chk(presence_n, 8'h00);
    chk(setpoint, 8'h5A);
    chk(8'({sda_o, alert_o}), 8'h00);
    for (int i = 0; i < 8; i++) begin
      {interlock_ok, rs485_mode, on_off_req_n} = 3'(i);
      tick(2);
      chk(main_out_en, 8'(interlock_ok & (rs485_mode | ~on_off_req_n)));
    end
    for (int i = 0; i < 5; i++) begin
      {fan_fail, over_temp_shutdown, over_volt_shutdown, internal_fault} = 4'((1 << i) >> 1);
      tick(2);
      chk(fault_n, 8'(i == 0));
    end
    for (int i = 0; i < 3; i++) begin
      regulation_warn = 1'(i == 1);
      out_in_regulation = 1'(i != 2);
      tick(3);
      chk(output_good_warn_n, 8'(i == 0));
    end
    overload = 1'b1;
    tick(3);
    n = 0;
    repeat (32) begin
      prev = output_good_warn_n;
      tick(1);
      n += int'(output_good_warn_n !== prev);
    end
    chk(8'(n), 8'h04);
    overload = 1'b0;
    sw_setpoint_wr = 1'b1;
    tick(1);
    sw_setpoint_wr = 1'b0;
    hw_setpoint = 8'h11;
    tick(2);
    chk(setpoint, 8'hC3);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(2);
    chk(setpoint, 8'h11);
    host_u.ara_read(adr, pec, ack);
    chk(ack, 8'h00);
    chk(adr >> 1, 8'h2A);
    chk(pec, crc(crc(8'h00, 8'h19), adr));
    chk(alert_oe, 8'h00);
    host_u.ara_read(adr, pec, ack);
    chk(ack, 8'h01);
    chk(adr, 8'hFF);
    chk(pec, 8'hFF);
    state_change = 1'b1;
    tick(1);
    state_change = 1'b0;
    rival = 1'b1;
    host_u.ara_read(adr, pec, ack);
    rival = 1'b0;
    chk(adr, 8'h00);
    chk(pec, 8'hFF);
    chk(alert_oe, 8'h01);
    if (alert_oe) host_u.ara_read(adr, pec, ack);
    chk(adr >> 1, 8'h2A);
    chk(alert_oe, 8'h00);
    state_change = 1'b1;
    clear_faults = 1'b1;
    tick(1);
    chk(alert_oe, 8'h01);
    {state_change, clear_faults} = 2'b01;
    tick(1);
    chk(alert_oe, 8'h00);
    {state_change, clear_faults} = 2'b10;
    tick(1);
    state_change = 1'b0;
    tick(1);
    chk(alert_oe, 8'h01);
    final_report();
  end
  initial begin
    #(20 * 20000);
    err_count++;
    final_report();
  end
endmodule // test_alert_response_status_ctrl

// ---- inc/arsc_pkg.sv ----
package arsc_pkg;

  // Alert-response address with the read bit set
  localparam logic [7:0] ARSC_ARA_RD_BYTE = 8'h19;
  localparam logic [7:0] ARSC_CRC_POLY = 8'h07;
  localparam logic [7:0] ARSC_CRC_INIT = 8'h00;
  localparam int ARSC_ADDR_W = 7;
  localparam int ARSC_SETPT_W = 8;
  localparam logic [3:0] ARSC_BIT_LAST = 4'h8;
  localparam logic ARSC_ADDR_LSB = 1'b1;

  localparam int ARSC_CLK_PERIOD_NS = 20;
  localparam int ARSC_PGW_TOGGLE_NS = 1000000;
  localparam int ARSC_PGW_TOGGLE_CYC = ARSC_PGW_TOGGLE_NS / ARSC_CLK_PERIOD_NS;
  localparam int ARSC_PGW_CNT_W = 16;

  // Reset levels
  localparam logic ARSC_ALERT_RST = 1'b1;
  localparam logic ARSC_PRES_N_RST = 1'b0;
  localparam logic ARSC_FAULT_N_RST = 1'b1;
  localparam logic ARSC_PGW_N_RST = 1'b0;

  typedef enum logic [2:0] {
    ARSC_IDLE,
    ARSC_ADDR,
    ARSC_ADDR_ACK,
    ARSC_TX,
    ARSC_HOST_ACK,
    ARSC_IGNORE
  } arsc_state_t;

  function automatic logic [7:0] arsc_crc8(input logic [7:0] crc_in, input logic [7:0] data);
    logic [7:0] c;
    c = crc_in ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ ARSC_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

endpackage

// ---- rtl/arsc_bus_sense.sv ----
`timescale 1ns/10ps
module arsc_bus_sense
  import arsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det,
  output logic sda_now
);

  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic scl_p;
    logic sda_p;
  } arsc_sense_t;

  arsc_sense_t st_ff;
  arsc_sense_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.scl_q = scl_i;
    nxt_st.sda_q = sda_i;
    nxt_st.scl_p = st_ff.scl_q;
    nxt_st.sda_p = st_ff.sda_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{scl_q: 1'b1, sda_q: 1'b1, scl_p: 1'b1, sda_p: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Host owns every clock edge; only sensed here
  assign scl_rise = st_ff.scl_q & ~st_ff.scl_p;
  assign scl_fall = ~st_ff.scl_q & st_ff.scl_p;
  assign start_det = st_ff.scl_q & st_ff.scl_p & st_ff.sda_p & ~st_ff.sda_q;
  assign stop_det = st_ff.scl_q & st_ff.scl_p & ~st_ff.sda_p & st_ff.sda_q;
  assign sda_now = st_ff.sda_q;

endmodule // arsc_bus_sense

// ---- rtl/arsc_top.sv ----
`timescale 1ns/10ps
// Contract
// - Pull shared alert low whenever internal state changes.
// - Answer alert-response read with own address only while alert asserted.
// - Sequence: start, ARA+read, ack, address, ack, PEC, nack, stop.
// - Wired-AND bitwise arbitration lets lowest responding address win.
// - Address byte holds 7-bit address in upper bits, lsb free.
// - Read back sent byte; release alert only if it matches own address.
// - Hardware setpoint rules until software setpoint written, then ignored.
// - After bias recycle, default config and hardware setpoint again.
// - Output on only while active-low on/off request held low.
// - Interlock released turns output off regardless of on/off request.
// - In RS485 mode the on/off request is ignored.
// - Presence output held low at all times.
// - Power-good warning high while delivered, low before regulation loss.
// - Power-good warning toggles every 1 ms while in overload.
// - Fault output low on fan, over-temp, over-voltage or internal fault.
// - Alert stays latched until clear-faults or a won alert-response read; bias recycle sets it.
// - PEC is CRC-8 x^8+x^2+x+1 over all bytes incl. address.
module arsc_top
  import arsc_pkg::*;
#(
  parameter int ADDR_W = ARSC_ADDR_W,
  parameter int SETPT_W = ARSC_SETPT_W,
  parameter int PGW_TOGGLE_CYC = ARSC_PGW_TOGGLE_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic alert_o,
  output logic alert_oe,
  input wire logic [ADDR_W-1:0] own_address,
  input wire logic state_change,
  input wire logic clear_faults,
  input wire logic on_off_req_n,
  input wire logic interlock_ok,
  input wire logic rs485_mode,
  input wire logic [SETPT_W-1:0] hw_setpoint,
  input wire logic [SETPT_W-1:0] sw_setpoint,
  input wire logic sw_setpoint_wr,
  input wire logic out_in_regulation,
  input wire logic regulation_warn,
  input wire logic overload,
  input wire logic fan_fail,
  input wire logic over_temp_shutdown,
  input wire logic over_volt_shutdown,
  input wire logic internal_fault,
  output logic main_out_en,
  output logic [SETPT_W-1:0] setpoint,
  output logic presence_n,
  output logic output_good_warn_n,
  output logic fault_n
);

  typedef struct packed {
    arsc_state_t fsm;
    logic [3:0] bit_cnt;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic [7:0] pec;
    logic is_pec;
    logic lost;
    logic drive_low;
    logic alert;
    logic main_en;
    logic sw_override;
    logic [SETPT_W-1:0] setpt;
    logic [ARSC_PGW_CNT_W-1:0] pgw_cnt;
    logic pgw_phase;
    logic pgw_n;
    logic fault_n;
    logic pres_n;
  } arsc_top_t;

  arsc_top_t st_ff;
  arsc_top_t nxt_st;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_now;
  logic [7:0] own_byte;
  logic alert_release;

  arsc_bus_sense u_sense (
    .clk(clk),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det),
    .sda_now(sda_now)
  );

  assign own_byte = {own_address, ARSC_ADDR_LSB};

  always_comb begin
    nxt_st = st_ff;
    alert_release = 1'b0;

    unique case (st_ff.fsm)
      ARSC_IDLE: begin
      end
      ARSC_ADDR: begin
        if (scl_rise) begin
          nxt_st.rx_byte = {st_ff.rx_byte[6:0], sda_now};
          nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
        end else if (scl_fall && st_ff.bit_cnt == ARSC_BIT_LAST) begin
          // Only an asserted alert may claim the alert-response read
          if (st_ff.rx_byte == ARSC_ARA_RD_BYTE && st_ff.alert) begin
            nxt_st.drive_low = 1'b1;
            nxt_st.fsm = ARSC_ADDR_ACK;
          end else begin
            nxt_st.fsm = ARSC_IGNORE;
          end
        end
      end
      ARSC_ADDR_ACK: begin
        if (scl_fall) begin
          nxt_st.tx_byte = own_byte;
          nxt_st.pec = arsc_crc8(arsc_crc8(ARSC_CRC_INIT, ARSC_ARA_RD_BYTE), own_byte);
          nxt_st.is_pec = 1'b0;
          nxt_st.lost = 1'b0;
          nxt_st.bit_cnt = 4'h0;
          nxt_st.drive_low = ~own_byte[7];
          nxt_st.fsm = ARSC_TX;
        end
      end
      ARSC_TX: begin
        if (scl_rise) begin
          nxt_st.rx_byte = {st_ff.rx_byte[6:0], sda_now};
          nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
          // Released a one but bus shows zero: lower address wins
          if (!st_ff.drive_low && !sda_now) begin
            nxt_st.lost = 1'b1;
          end
        end else if (scl_fall) begin
          if (st_ff.bit_cnt == ARSC_BIT_LAST) begin
            nxt_st.drive_low = 1'b0;
            nxt_st.fsm = ARSC_HOST_ACK;
            if (!st_ff.is_pec && !st_ff.lost && st_ff.rx_byte[7:1] == own_address) begin
              alert_release = 1'b1;
            end
          end else begin
            nxt_st.tx_byte = {st_ff.tx_byte[6:0], 1'b0};
            // Once beaten, stay off the line for the rest of the byte
            nxt_st.drive_low = ~st_ff.lost & ~st_ff.tx_byte[6];
          end
        end
      end
      ARSC_HOST_ACK: begin
        if (scl_rise) begin
          nxt_st.rx_byte = {st_ff.rx_byte[6:0], sda_now};
        end else if (scl_fall) begin
          if (st_ff.is_pec || st_ff.lost || st_ff.rx_byte[0]) begin
            nxt_st.fsm = ARSC_IGNORE;
          end else begin
            nxt_st.tx_byte = st_ff.pec;
            nxt_st.is_pec = 1'b1;
            nxt_st.bit_cnt = 4'h0;
            nxt_st.drive_low = ~st_ff.pec[7];
            nxt_st.fsm = ARSC_TX;
          end
        end
      end
      ARSC_IGNORE: begin
      end
    endcase

    // Start and stop override any byte in flight
    if (start_det) begin
      nxt_st.fsm = ARSC_ADDR;
      nxt_st.bit_cnt = 4'h0;
      nxt_st.drive_low = 1'b0;
    end else if (stop_det) begin
      nxt_st.fsm = ARSC_IDLE;
      nxt_st.drive_low = 1'b0;
    end

    // New state change wins over any clear in the same cycle
    if (state_change) begin
      nxt_st.alert = 1'b1;
    end else if (clear_faults || alert_release) begin
      nxt_st.alert = 1'b0;
    end

    // Software setpoint latches until bias recycle (reset)
    if (sw_setpoint_wr) begin
      nxt_st.sw_override = 1'b1;
      nxt_st.setpt = sw_setpoint;
    end else if (!st_ff.sw_override) begin
      nxt_st.setpt = hw_setpoint;
    end

    nxt_st.main_en = interlock_ok & (rs485_mode | ~on_off_req_n);

    // Overload blink train; counter idles otherwise to keep phase defined
    if (overload) begin
      if (st_ff.pgw_cnt >= ARSC_PGW_CNT_W'(PGW_TOGGLE_CYC - 1)) begin
        nxt_st.pgw_cnt = '0;
        nxt_st.pgw_phase = ~st_ff.pgw_phase;
      end else begin
        nxt_st.pgw_cnt = st_ff.pgw_cnt + ARSC_PGW_CNT_W'(1);
      end
      nxt_st.pgw_n = st_ff.pgw_phase;
    end else begin
      nxt_st.pgw_cnt = '0;
      nxt_st.pgw_phase = 1'b0;
      nxt_st.pgw_n = st_ff.main_en & out_in_regulation & ~regulation_warn;
    end

    nxt_st.fault_n = ~(fan_fail | over_temp_shutdown | over_volt_shutdown | internal_fault);
    nxt_st.pres_n = 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{fsm: ARSC_IDLE, bit_cnt: 4'h0, rx_byte: 8'h00, tx_byte: 8'h00, pec: 8'h00,
                 is_pec: 1'b0, lost: 1'b0, drive_low: 1'b0, alert: ARSC_ALERT_RST, main_en: 1'b0,
                 sw_override: 1'b0, setpt: '0, pgw_cnt: '0, pgw_phase: 1'b0,
                 pgw_n: ARSC_PGW_N_RST, fault_n: ARSC_FAULT_N_RST, pres_n: ARSC_PRES_N_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Open-drain pins only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe = st_ff.drive_low;
  assign alert_o = 1'b0;
  assign alert_oe = st_ff.alert;
  assign main_out_en = st_ff.main_en;
  assign setpoint = st_ff.setpt;
  assign presence_n = st_ff.pres_n;
  assign output_good_warn_n = st_ff.pgw_n;
  assign fault_n = st_ff.fault_n;

endmodule // arsc_top
